// file: terminal_run_jog.sv
// Terminal block start, jog, direction and speed select decoder
// Operation
// - Two-wire run configured blocks other starts
// - Three-wire start edge runs unless stop open
// - Start needs start and logic mask
// - Direction input open forward, closed reverse
// - Direction needs direction and logic mask
// - Foreign direction owner blocks terminal start, direction and jog direction, not plain jog
// - Direction ownership sought while function configured
// - Jog edge jogs, opening jog stops
// - No jog while running or stop open
// - Start during jog switches to run
// - Plain jog needs jog and logic mask
// - Jog forward/reverse table with ownership
// - Unconfigured jog direction reads as open
// - Jog direction needs jog, direction, logic masks
// - Closing jog direction takes free ownership
// - Three select bits pick A, B, presets
// - A/B pick further source, preset direct
// - Speed select needs reference and logic mask
// - Foreign reference owner makes selects inert
// - Reference ownership sought while select configured
// - Unconfigured speed select reads as zero
// - Start without stop raises configuration alarm
`timescale 1ns/10ps
`default_nettype none
`include "terminal_cmd_params.svh"

module terminal_run_jog
  import terminal_cmd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic start3_i,
  input wire logic stop_clr_i,
  input wire logic dir_sel_i,
  input wire logic jog_i,
  input wire logic jog_fwd_i,
  input wire logic jog_rev_i,
  input wire logic [2:0] spd_sel_i,
  input wire logic run2_cfg_i,
  input wire logic start3_cfg_i,
  input wire logic stop_cfg_i,
  input wire logic dir_cfg_i,
  input wire logic jog_cfg_i,
  input wire logic jog_fwd_cfg_i,
  input wire logic jog_rev_cfg_i,
  input wire logic [2:0] spd_cfg_i,
  input wire logic start_mask_i,
  input wire logic dir_mask_i,
  input wire logic jog_mask_i,
  input wire logic ref_mask_i,
  input wire logic logic_mask_i,
  input wire logic dir_other_i,
  input wire logic ref_other_i,
  input wire logic shutdown_i,
  input wire logic stop_req_i,
  input wire logic ext_start_i,
  input wire logic ext_jog_i,
  output logic run_o,
  output logic jog_o,
  output logic reverse_o,
  output logic dir_owner_o,
  output logic ref_owner_o,
  output logic [2:0] ref_code_o,
  output logic ref_preset_o,
  output logic ext_lock_o,
  output logic cfg_alarm_o
);

  // ==========================================================
  // Reset release through two flops
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_meta_reg <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_meta_reg <= 1'h1;
      rst_n <= rst_meta_reg;
    end
  end

  // ==========================================================
  // Input conditioning
  logic [`TB_FN_COUNT-1:0] pins;
  logic [`TB_FN_COUNT-1:0] lvl;
  logic [`TB_FN_COUNT-1:0] rise;

  assign pins = {spd_sel_i, jog_rev_i, jog_fwd_i, jog_i,
                 dir_sel_i, stop_clr_i, start3_i};

  // Pins come from contacts, so they are synchronised first
  input_edge_sampler #(
    .WIDTH(`TB_FN_COUNT)
  ) u_sampler (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .pin_i(pins),
    .level_o(lvl),
    .rise_o(rise)
  );

  // ==========================================================
  // Gating terms
  logic stop_ok;
  logic start_en;
  logic tb_start;
  logic ext_ok;
  logic start_cmd;
  logic jog_en;
  logic jfr_cfg;
  logic jfr_en;
  logic jf;
  logic jr;
  logic jf_rise;
  logic jr_rise;
  logic jog_start;
  logic jog_held;
  logic [2:0] spd_lvl;

  // Unconfigured stop counts as closed, so only an open stop blocks
  assign stop_ok = ~stop_cfg_i | lvl[`TB_FN_STOP];
  assign start_en = start3_cfg_i & start_mask_i
                  & logic_mask_i & ~dir_other_i;
  assign tb_start = start_en & rise[`TB_FN_START] & stop_ok;
  // A wired two-wire mode locks every other device out
  assign ext_ok = ~run2_cfg_i;
  assign start_cmd = tb_start | (ext_start_i & ext_ok);

  assign jog_en = jog_cfg_i & jog_mask_i & logic_mask_i;
  assign jfr_cfg = jog_fwd_cfg_i | jog_rev_cfg_i;
  assign jfr_en = jfr_cfg & jog_mask_i & dir_mask_i
                & logic_mask_i & ~dir_other_i;
  // Missing half of the pair reads as open
  assign jf = jog_fwd_cfg_i & lvl[`TB_FN_JOGF];
  assign jr = jog_rev_cfg_i & lvl[`TB_FN_JOGR];
  assign jf_rise = jog_fwd_cfg_i & rise[`TB_FN_JOGF];
  assign jr_rise = jog_rev_cfg_i & rise[`TB_FN_JOGR];

  // Jog is a non-latched start from any allowed source
  assign jog_start = stop_ok
    & ((jog_en & rise[`TB_FN_JOG])
    | (jfr_en & (jf_rise | jr_rise))
    | (ext_jog_i & ext_ok));
  assign jog_held = (jog_en & lvl[`TB_FN_JOG])
                  | (jfr_en & (jf | jr))
                  | (ext_jog_i & ext_ok);

  // ==========================================================
  // Drive command state machine
  drive_state_t state_reg;
  drive_state_t state_next;

  // Start wins over jog in every state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_cmd) begin
          state_next = ST_RUN;
        end else if (jog_start) begin
          state_next = ST_JOG;
        end
      end
      ST_RUN: begin
        // Jog requests are ignored here
        if (stop_req_i || !stop_ok) begin
          state_next = ST_IDLE;
        end
      end
      ST_JOG: begin
        if (stop_req_i || !stop_ok) begin
          state_next = ST_IDLE;
        end else if (start_cmd) begin
          state_next = ST_RUN;
        end else if (!jog_held) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Direction ownership and direction
  logic dir_own_reg;
  logic dir_own_next;
  logic rev_reg;
  logic rev_next;
  logic dir_want;
  logic dir_perm;

  assign dir_perm = dir_mask_i & logic_mask_i;
  // An open select still commands forward, so it asks at once
  assign dir_want = dir_cfg_i | (jfr_cfg & (jf | jr));

  always_comb begin
    dir_own_next = dir_own_reg;
    rev_next = rev_reg;
    if (shutdown_i || !dir_perm || !dir_want) begin
      dir_own_next = 1'h0;
    end else if (!dir_own_reg && !dir_other_i) begin
      dir_own_next = 1'h1;
    end
    if (dir_own_reg) begin
      if (jfr_en && (jf ^ jr)) begin
        rev_next = jr;
      end else if (dir_cfg_i && !(jfr_en && jf && jr)) begin
        // Follows level, so a change while running reverses
        rev_next = lvl[`TB_FN_DIR];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      dir_own_reg <= 1'h0;
      rev_reg <= `DIR_REV_RST;
    end else begin
      dir_own_reg <= dir_own_next;
      rev_reg <= rev_next;
    end
  end

  // ==========================================================
  // Reference ownership and speed select code
  logic ref_own_reg;
  logic ref_own_next;
  logic [`SPD_W-1:0] code_reg;
  logic [`SPD_W-1:0] code_next;
  logic preset_reg;
  logic preset_next;
  logic ref_perm;

  assign ref_perm = ref_mask_i & logic_mask_i;
  // Unconfigured selects count as open, a zero bit
  assign spd_lvl = lvl[`TB_FN_SPD_HI:`TB_FN_SPD_LO] & spd_cfg_i;

  always_comb begin
    ref_own_next = ref_own_reg;
    code_next = code_reg;
    if (shutdown_i || !ref_perm || !(|spd_cfg_i)) begin
      ref_own_next = 1'h0;
    end else if (!ref_own_reg && !ref_other_i) begin
      ref_own_next = 1'h1;
    end
    // Code only moves while the terminal block owns selection
    if (ref_own_reg && ref_own_next) begin
      code_next = spd_lvl;
    end
    // Codes 2..7 are presets; 0 and 1 point at A and B
    preset_next = code_next[2] | code_next[1];
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ref_own_reg <= 1'h0;
      code_reg <= `SPD_CODE_RST;
      preset_reg <= 1'h0;
    end else begin
      ref_own_reg <= ref_own_next;
      code_reg <= code_next;
      preset_reg <= preset_next;
    end
  end

  // ==========================================================
  // Configuration status flags
  logic alarm_reg;
  logic alarm_next;
  logic lock_reg;
  logic lock_next;

  always_comb begin
    // Three-wire start without a stop input cannot be stopped
    alarm_next = start3_cfg_i & ~stop_cfg_i;
    lock_next = run2_cfg_i;
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= 1'h0;
      lock_reg <= 1'h0;
    end else begin
      alarm_reg <= alarm_next;
      lock_reg <= lock_next;
    end
  end

  // ==========================================================
  // Outputs, each a flop
  assign run_o = state_reg[`ST_RUN_BIT];
  assign jog_o = state_reg[`ST_JOG_BIT];
  assign reverse_o = rev_reg;
  assign dir_owner_o = dir_own_reg;
  assign ref_owner_o = ref_own_reg;
  assign ref_code_o = code_reg;
  assign ref_preset_o = preset_reg;
  assign ext_lock_o = lock_reg;
  assign cfg_alarm_o = alarm_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n);

  a_ext_start_lock: assert property (
    (state_reg == ST_IDLE && run2_cfg_i && !tb_start && !jog_start)
    |=> state_reg == ST_IDLE)
    else $error("start taken from another device in two-wire mode");

  a_start_runs: assert property (
    (state_reg == ST_IDLE && tb_start) |=> run_o && !jog_o)
    else $error("three-wire start edge did not run");

  a_start_masked: assert property (
    (state_reg == ST_IDLE && !(start_mask_i && logic_mask_i)
     && !(ext_start_i && ext_ok) && !jog_start)
    |=> !run_o)
    else $error("start taken without masks");

  a_dir_follow: assert property (
    (dir_own_reg && dir_cfg_i && !jfr_cfg)
    |=> reverse_o == $past(lvl[`TB_FN_DIR]))
    else $error("direction does not follow select");

  a_dir_foreign: assert property (
    (!dir_own_reg && dir_other_i) |=> !dir_owner_o)
    else $error("took direction from another owner");

  a_dir_release: assert property (
    (!dir_perm || shutdown_i) |=> !dir_owner_o)
    else $error("direction kept without masks");

  a_jog_open_stop: assert property (
    (state_reg == ST_JOG && !jog_held && !start_cmd)
    |=> state_reg == ST_IDLE)
    else $error("jog kept after input opened");

  a_run_no_jog: assert property (
    (state_reg == ST_RUN && stop_ok && !stop_req_i)
    |=> run_o && !jog_o)
    else $error("run disturbed by jog");

  a_jog_to_run: assert property (
    (state_reg == ST_JOG && start_cmd && stop_ok && !stop_req_i)
    |=> run_o ##0 !jog_o)
    else $error("start during jog did not switch to run");

  a_ref_code: assert property (
    (ref_own_reg && ref_own_next)
    |=> ref_code_o == $past(spd_lvl))
    else $error("speed code not taken");

  a_ref_inert: assert property (
    (!ref_own_reg) |=> $stable(ref_code_o))
    else $error("speed code moved without ownership");

  a_ref_preset: assert property (
    ref_preset_o == (ref_code_o[2] | ref_code_o[1]))
    else $error("preset flag disagrees with code");

  // Configuration may change at any cycle, so only the next one is owed
  a_cfg_alarm: assert property (
    (start3_cfg_i && !stop_cfg_i) |=> cfg_alarm_o)
    else $error("missing configuration alarm");

  c_run: cover property (state_reg == ST_IDLE ##1 run_o);
  c_jog: cover property (state_reg == ST_IDLE ##1 jog_o ##[1:20] !jog_o);
  c_jog_run: cover property (jog_o ##1 run_o);
  c_dir_rev: cover property (dir_owner_o && $rose(reverse_o) && run_o);

endmodule : terminal_run_jog
`default_nettype wire

// file: terminal_cmd_params.svh
// Bit positions, state codes and reset values for the terminal command decoder
`ifndef TERMINAL_CMD_PARAMS_SVH
`define TERMINAL_CMD_PARAMS_SVH

// ==========================================================
// Positions of the conditioned terminal functions
`define TB_FN_COUNT 9
`define TB_FN_START 0
`define TB_FN_STOP 1
`define TB_FN_DIR 2
`define TB_FN_JOG 3
`define TB_FN_JOGF 4
`define TB_FN_JOGR 5
`define TB_FN_SPD_LO 6
`define TB_FN_SPD_HI 8

// ==========================================================
// One-hot drive state codes and their bit positions
`define ST_IDLE_CODE 3'h1
`define ST_RUN_CODE 3'h2
`define ST_JOG_CODE 3'h4
`define ST_RUN_BIT 1
`define ST_JOG_BIT 2

// ==========================================================
// Speed select code layout and reset values
`define SPD_W 3
`define SPD_CODE_RST 3'h0
`define DIR_REV_RST 1'h0

`endif

// file: terminal_cmd_pkg.sv
// Types shared by the terminal command decoder
`include "terminal_cmd_params.svh"

package terminal_cmd_pkg;

  // ==========================================================
  // Drive command state, one-hot
  typedef enum logic [2:0] {
    ST_IDLE = `ST_IDLE_CODE,
    ST_RUN = `ST_RUN_CODE,
    ST_JOG = `ST_JOG_CODE
  } drive_state_t;

endpackage : terminal_cmd_pkg

// file: input_edge_sampler.sv
// Two-stage synchroniser and open-to-closed edge finder for terminal inputs
`timescale 1ns/10ps
`default_nettype none

module input_edge_sampler #(
  parameter int WIDTH = 9
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o
);

  // ==========================================================
  // Elaboration check
  if (WIDTH < 1) begin : g_bad_width
    $error("input_edge_sampler needs WIDTH of at least 1");
  end

  // ==========================================================
  // Per-bit sampling; the first stage feeds only the second
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;
    logic meta_next;
    logic sync_next;
    logic prev_next;

    // Next values of the three stages
    always_comb begin
      meta_next = pin_i[i];
      sync_next = meta_reg;
      prev_next = sync_reg;
    end

    // Registers only
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_reg <= 1'h0;
        sync_reg <= 1'h0;
        prev_reg <= 1'h0;
      end else begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
        prev_reg <= prev_next;
      end
    end

    // Closed now, open one sample ago
    assign level_o[i] = sync_reg;
    assign rise_o[i] = sync_reg & ~prev_reg;
  end

endmodule : input_edge_sampler
`default_nettype wire

// file: contact_bank.sv
// Terminal block contact bank driving the decoder pins
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Contacts
module contact_bank (
  input wire logic mclk_i,
  input wire logic [8:0] want_i,
  output logic [8:0] pin_o
);
  // Contacts move just after an edge, never in the sampling step
  initial pin_o = 9'h000;
  always @(posedge mclk_i) begin
    pin_o <= want_i;
  end
endmodule : contact_bank
`default_nettype wire

// file: tb.sv
// Self-checking bench for the terminal start, jog and speed decoder
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Bench
module tb;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  // Contacts: 0 start, 1 stop, 2 dir, 3 jog, 4 jog fwd, 5 jog rev, 8:6 speed
  logic [8:0] want = 9'h000;
  logic [8:0] pin;
  logic r2c = 0, stc = 0, spc = 0, drc = 0, jgc = 0, jfc = 0, jrc = 0;
  logic [2:0] sdc = 3'h0;
  logic mst = 0, mdr = 0, mjg = 0, mrf = 0, mlg = 0;
  logic doth = 0, roth = 0, shut = 0, stp = 0, xst = 0, xjg = 0;
  logic run, jog, rev, down, rown, pre, lock, alarm;
  logic [2:0] code;
  int error_cnt = 0;
  int tests_run = 0;

  // Clock, 5 ns period
  always #2.5 mclk_i = ~mclk_i;

  contact_bank i_bank (.mclk_i(mclk_i), .want_i(want), .pin_o(pin));

  terminal_run_jog i_dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .start3_i(pin[0]), .stop_clr_i(pin[1]), .dir_sel_i(pin[2]),
    .jog_i(pin[3]), .jog_fwd_i(pin[4]), .jog_rev_i(pin[5]),
    .spd_sel_i(pin[8:6]), .run2_cfg_i(r2c), .start3_cfg_i(stc),
    .stop_cfg_i(spc), .dir_cfg_i(drc), .jog_cfg_i(jgc),
    .jog_fwd_cfg_i(jfc), .jog_rev_cfg_i(jrc), .spd_cfg_i(sdc),
    .start_mask_i(mst), .dir_mask_i(mdr), .jog_mask_i(mjg),
    .ref_mask_i(mrf), .logic_mask_i(mlg), .dir_other_i(doth),
    .ref_other_i(roth), .shutdown_i(shut), .stop_req_i(stp),
    .ext_start_i(xst), .ext_jog_i(xjg), .run_o(run), .jog_o(jog),
    .reverse_o(rev), .dir_owner_o(down), .ref_owner_o(rown),
    .ref_code_o(code), .ref_preset_o(pre), .ext_lock_o(lock),
    .cfg_alarm_o(alarm)
  );

  // ==========================================================
  // Tasks
  task automatic wt(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : wt

  // Ends on a falling edge so outputs are settled when read
  task automatic settle(input int n);
    wt(n);
    @(negedge mclk_i);
  endtask : settle

  // Pin paths take four edges; six leaves margin
  task automatic setw(input int b, input logic v);
    @(posedge mclk_i);
    want[b] <= v;
    settle(6);
  endtask : setw

  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Stop from elsewhere, one cycle wide
  task automatic halt();
    @(posedge mclk_i);
    stp <= 1'b1;
    @(posedge mclk_i);
    stp <= 1'b0;
    settle(1);
    chk("run_halt", run, 0);
  endtask : halt

  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Watchdog far beyond the few hundred cycles of the tests
  initial begin
    wt(20000);
    error_cnt++;
    wrap_up();
  end

  // ==========================================================
  // Tests
  initial begin
    wt(20);
    rst_b_i <= 1'b1;
    settle(4);
    chk("run_rst", run, 0);
    chk("code_rst", code, 0);
    @(posedge mclk_i);
    stc <= 1'b1;
    spc <= 1'b1;
    drc <= 1'b1;
    jgc <= 1'b1;
    sdc <= 3'h7;
    {mst, mdr, mjg, mrf, mlg} <= 5'h1f;
    want[1] <= 1'b1;
    settle(6);
    chk("dir_own", down, 1);
    chk("ref_own", rown, 1);
    chk("alarm_ok", alarm, 0);
    // Every speed code in turn
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk_i);
      want[8:6] <= i[2:0];
      settle(6);
      chk("code", code, i[3:0]);
      chk("preset", pre, i > 1);
    end
    @(posedge mclk_i);
    sdc <= 3'h1;
    settle(6);
    chk("code_sel1", code, 4'h1);
    @(posedge mclk_i);
    sdc <= 3'h6;
    settle(6);
    chk("code_sel32", code, 4'h6);
    @(posedge mclk_i);
    mrf <= 1'b0;
    roth <= 1'b1;
    settle(2);
    chk("ref_mask", rown, 0);
    @(posedge mclk_i);
    mrf <= 1'b1;
    want[8:6] <= 3'h0;
    settle(6);
    chk("ref_foreign", rown, 0);
    chk("code_frozen", code, 4'h6);
    @(posedge mclk_i);
    roth <= 1'b0;
    shut <= 1'b1;
    settle(2);
    chk("ref_shut", rown, 0);
    chk("dir_shut", down, 0);
    @(posedge mclk_i);
    shut <= 1'b0;
    setw(2, 1);
    chk("rev_closed", rev, 1);
    setw(0, 1);
    setw(0, 0);
    chk("run_start", run, 1);
    setw(3, 1);
    chk("jog_in_run", jog, 0);
    setw(3, 0);
    setw(2, 0);
    chk("rev_flip", rev, 0);
    halt();
    @(posedge mclk_i);
    mst <= 1'b0;
    setw(0, 1);
    setw(0, 0);
    chk("run_nomask", run, 0);
    @(posedge mclk_i);
    mst <= 1'b1;
    setw(1, 0);
    setw(0, 1);
    chk("run_stopopen", run, 0);
    setw(3, 1);
    chk("jog_stopopen", jog, 0);
    setw(3, 0);
    setw(0, 0);
    setw(1, 1);
    @(posedge mclk_i);
    mjg <= 1'b0;
    setw(3, 1);
    chk("jog_nomask", jog, 0);
    setw(3, 0);
    @(posedge mclk_i);
    mjg <= 1'b1;
    setw(3, 1);
    chk("jog_on", jog, 1);
    setw(3, 0);
    chk("jog_off", jog, 0);
    setw(3, 1);
    @(posedge mclk_i);
    xst <= 1'b1;
    @(posedge mclk_i);
    xst <= 1'b0;
    settle(1);
    chk("run_from_jog", run, 1);
    chk("jog_left", jog, 0);
    setw(3, 0);
    halt();
    // Jog forward and reverse pair
    @(posedge mclk_i);
    drc <= 1'b0;
    jfc <= 1'b1;
    jrc <= 1'b1;
    settle(2);
    chk("dir_unassigned", down, 0);
    setw(5, 1);
    chk("jr_jog", jog, 1);
    chk("jr_rev", rev, 1);
    chk("jr_own", down, 1);
    setw(4, 1);
    chk("both_jog", jog, 1);
    chk("both_rev", rev, 1);
    setw(5, 0);
    chk("jf_fwd", rev, 0);
    setw(4, 0);
    chk("open_jog", jog, 0);
    chk("open_own", down, 0);
    @(posedge mclk_i);
    jrc <= 1'b0;
    setw(5, 1);
    chk("jr_unassigned", jog, 0);
    setw(5, 0);
    @(posedge mclk_i);
    mdr <= 1'b0;
    setw(4, 1);
    chk("jf_nomask", jog, 0);
    setw(4, 0);
    @(posedge mclk_i);
    mdr <= 1'b1;
    doth <= 1'b1;
    setw(4, 1);
    chk("jf_foreign", jog, 0);
    chk("own_foreign", down, 0);
    setw(4, 0);
    setw(0, 1);
    chk("run_foreign", run, 0);
    setw(0, 0);
    @(posedge mclk_i);
    doth <= 1'b0;
    r2c <= 1'b1;
    xst <= 1'b1;
    settle(2);
    chk("lock_on", lock, 1);
    chk("ext_start", run, 0);
    @(posedge mclk_i);
    xst <= 1'b0;
    xjg <= 1'b1;
    settle(2);
    chk("ext_jog", jog, 0);
    @(posedge mclk_i);
    xjg <= 1'b0;
    r2c <= 1'b0;
    spc <= 1'b0;
    settle(2);
    chk("alarm_on", alarm, 1);
    chk("lock_off", lock, 0);
    // Lock lifted: a held jog from another device now counts
    @(posedge mclk_i);
    xjg <= 1'b1;
    settle(2);
    chk("ext_jog_free", jog, 1);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
